// ===== core/scor_regs.sv
// Purpose: System control register bank: debug force reset, part id, options one.
// Assumes: One bus clock, synchronous active-high reset, same-clock bus strobes.
// Notes:   Pin routing and stop handling live elsewhere; this block drives their selects.

// Summary of operation
// - CPU writes to force-reset register are ignored
// - Force-reset register always reads zero
// - Debug write of bit0 one forces reset
// - Force-reset bits 7..1 read zero
// - High id: upper nibble zero, id high bits
// - Low id read-only, holds id low part
// - Options at 3004h, resets to 0Ch
// - Bit7 routes serial interface pins
// - Bit6 routes SPI pins
// - Bit5 routes two-wire pins
// - Bit4 routes timer2 channel pins
// - Bit1 fast wakeup skips interrupt service
// - Bit0 stop allow; stop when clear resets
module scor_regs #(
    parameter logic [11:0] PART_ID = 12'h5a3 // Arbitrary neutral value.
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // CPU bus
    input  wire logic [15:0] cpu_addr_i,
    input  wire logic        cpu_wr_i,
    input  wire logic        cpu_rd_i,
    input  wire logic [7:0]  cpu_wdata_i,
    output logic      [7:0]  cpu_rdata_o,
    // Background debug write path
    input  wire logic [15:0] dbg_addr_i,
    input  wire logic        dbg_wr_i,
    input  wire logic [7:0]  dbg_wdata_i,
    // CPU low-power events
    input  wire logic        stop_exec_i,
    // Routing and control selects
    output logic             serial_iface_pin_select_o,
    output logic             spi_pin_select_o,
    output logic             two_wire_pin_select_o,
    output logic             timer2_pin_select_o,
    output logic             fast_wakeup_enable_o,
    output logic             stop_allow_o,
    output logic             stop_enter_o,
    // Reset requests
    output logic             force_reset_o,
    output logic             illegal_stop_reset_o
);
    // Every register in the bank is one byte wide.
    localparam int         REG_W   = 8;
    // Upper nibble of the high identity byte is reserved and reads zero.
    localparam logic [3:0] ID_RSVD = 4'h0;

    // Read data and the three one-cycle pulses; the option bits live in their own cells.
    typedef struct packed {
        logic [REG_W-1:0] rdata;
        logic             frc;
        logic             ilop;
        logic             stop;
    } scor_state_t;

    scor_state_t      st_reg;
    scor_state_t      st_next;

    // Decode and read sources
    logic             dbg_frc_hit;
    logic             cpu_opt_wr;
    logic [REG_W-1:0] opt_value;
    logic [REG_W-1:0] idh_value;
    logic [REG_W-1:0] idl_value;
    logic             stop_ok;
    logic             stop_bad;

    // Only the debug strobe is decoded for the force-reset register. A CPU write to
    // the same address has no path into it, so a runaway program cannot reset the part.
    assign dbg_frc_hit = dbg_wr_i &&
                         (dbg_addr_i == scor_pkg::SCOR_FRC_ADDR);

    assign cpu_opt_wr  = cpu_wr_i &&
                         (cpu_addr_i == scor_pkg::SCOR_OPT_ADDR);

    // The identity bytes are wired from the part number; no write path exists.
    assign idh_value   = {ID_RSVD, PART_ID[11:8]};
    assign idl_value   = PART_ID[7:0];

    // Each option bit except reserved bits 3 and 2 sits in its own write-once cell. Every write carries the whole
    // byte, so all cells lock together on the first write after reset.
    for (genvar gi = 0; gi < REG_W; gi++) begin : g_opt
        if (scor_pkg::SCOR_OPT_RSVD_M[gi]) begin : g_rsvd
            // Tied high, so a careless write of zero cannot clear them.
            assign opt_value[gi] = 1'b1;
        end else begin : g_once
            scor_once_bit #(
                .RESET_VAL (scor_pkg::SCOR_OPT_RESET[gi])
            ) scor_once_bit_i (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .wr_i      (cpu_opt_wr),
                .wdata_i   (cpu_wdata_i[gi]),
                .value_o   (opt_value[gi])
            );
        end
    end

    // A stop instruction either enters stop or, with stop not allowed, requests a reset.
    assign stop_ok     = stop_exec_i && opt_value[scor_pkg::SCOR_STOP_POS];
    assign stop_bad    = stop_exec_i && !opt_value[scor_pkg::SCOR_STOP_POS];

    always_comb begin
        st_next       = st_reg;
        // Pulses clear unless set again in this cycle.
        st_next.frc   = 1'b0;
        st_next.ilop  = 1'b0;
        st_next.stop  = 1'b0;
        st_next.rdata = scor_pkg::SCOR_ZERO;

        if (dbg_frc_hit) begin
            st_next.frc = dbg_wdata_i[scor_pkg::SCOR_FRC_POS];
        end
        if (stop_ok) begin
            st_next.stop = 1'b1;
        end
        if (stop_bad) begin
            st_next.ilop = 1'b1;
        end

        // The force-reset address has no read source and falls to the zero default.
        if (cpu_rd_i) begin
            case (cpu_addr_i)
                scor_pkg::SCOR_IDH_ADDR: begin
                    st_next.rdata = idh_value;
                end
                scor_pkg::SCOR_IDL_ADDR: begin
                    st_next.rdata = idl_value;
                end
                scor_pkg::SCOR_OPT_ADDR: begin
                    st_next.rdata = opt_value;
                end
                default: begin
                    st_next.rdata = scor_pkg::SCOR_ZERO;
                end
            endcase
        end
    end

    // Synchronous reset clears the read data and all pulses.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Read data is registered and stands for one cycle after the read strobe.
    assign cpu_rdata_o               = st_reg.rdata;

    // Routing selects; the pin multiplexers themselves sit outside this block.
    assign serial_iface_pin_select_o = opt_value[scor_pkg::SCOR_SER_POS];
    assign spi_pin_select_o          = opt_value[scor_pkg::SCOR_SPI_POS];
    assign two_wire_pin_select_o     = opt_value[scor_pkg::SCOR_TWI_POS];
    assign timer2_pin_select_o       = opt_value[scor_pkg::SCOR_TMR_POS];

    // Low-power controls. The fast-wakeup level only tells the CPU how to resume;
    // the resume path itself is not modelled here.
    assign fast_wakeup_enable_o      = opt_value[scor_pkg::SCOR_WAKE_POS];
    assign stop_allow_o              = opt_value[scor_pkg::SCOR_STOP_POS];

    // One-cycle pulses. The integrator must route both reset requests into the
    // system reset, which in turn clears this bank.
    assign stop_enter_o              = st_reg.stop;
    assign force_reset_o             = st_reg.frc;
    assign illegal_stop_reset_o      = st_reg.ilop;
endmodule : scor_regs

// One write-once option bit. It takes the first write after reset and then holds
// its value until the next reset; later writes are dropped without any error.
module scor_once_bit #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Write request
    input  wire logic wr_i,
    input  wire logic wdata_i,
    // Held value
    output logic      value_o
);

    typedef struct packed {
        logic value;
        logic locked;
    } scor_once_t;

    scor_once_t st_reg;
    scor_once_t st_next;

    // The lock bit is what makes the cell write-once; only reset reopens it.
    always_comb begin
        st_next = st_reg;
        if (wr_i && !st_reg.locked) begin
            st_next.value  = wdata_i;
            st_next.locked = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg.value  <= RESET_VAL;
            st_reg.locked <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign value_o = st_reg.value;
endmodule : scor_once_bit

// ===== core/scor_pkg.sv
// Purpose: Constants for the system control and options register bank.
// Assumes: 8-bit CPU bus and a separate background debug write strobe.
// Notes:   Offsets of the debug and identity registers are chosen within the 3000h page.
package scor_pkg;
    localparam logic [15:0] SCOR_BASE        = 16'h3000;
    localparam logic [15:0] SCOR_FRC_ADDR    = 16'h3001;
    localparam logic [15:0] SCOR_IDH_ADDR    = 16'h3002;
    localparam logic [15:0] SCOR_IDL_ADDR    = 16'h3003;
    localparam logic [15:0] SCOR_OPT_ADDR    = 16'h3004;
    localparam logic [7:0]  SCOR_OPT_RESET   = 8'h0c;
    localparam logic [7:0]  SCOR_OPT_RSVD_M  = 8'h0c;
    localparam int          SCOR_SER_POS     = 7;
    localparam int          SCOR_SPI_POS     = 6;
    localparam int          SCOR_TWI_POS     = 5;
    localparam int          SCOR_TMR_POS     = 4;
    localparam int          SCOR_WAKE_POS    = 1;
    localparam int          SCOR_STOP_POS    = 0;
    localparam int          SCOR_FRC_POS     = 0;
    localparam logic [7:0]  SCOR_ZERO        = 8'h00;
endpackage : scor_pkg

// ===== test/scor_regs_monitor.sv
// Purpose: Port checker for scor_regs. Assumes: one clock. Notes: bound below.
module scor_regs_monitor (
    input wire logic clk_i, rst_i, cpu_rd_i, dbg_wr_i, stop_exec_i, spi_pin_select_o,
    input wire logic stop_allow_o, stop_enter_o, force_reset_o, illegal_stop_reset_o,
    input wire logic [15:0] cpu_addr_i, dbg_addr_i,
    input wire logic [7:0] cpu_rdata_o, dbg_wdata_i);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic dbg_frc;
    assign dbg_frc = dbg_wr_i && dbg_addr_i == 16'h3001 && dbg_wdata_i[0];
    property p_frc; dbg_frc |=> force_reset_o; endproperty
    a_frc: assert property (p_frc) else $error("force reset missing");
    property p_cpu; !dbg_frc |=> !force_reset_o; endproperty
    a_cpu: assert property (p_cpu) else $error("stray force reset");
    property p_rd0; cpu_rd_i && cpu_addr_i == 16'h3001 |=> cpu_rdata_o == 8'h00; endproperty
    a_rd0: assert property (p_rd0) else $error("force reg read not zero");
    property p_opt; cpu_rd_i && cpu_addr_i == 16'h3004 |=> cpu_rdata_o[3:2] == 2'b11; endproperty
    a_opt: assert property (p_opt) else $error("options reserved bits");
    property p_idh; cpu_rd_i && cpu_addr_i == 16'h3002 |=> cpu_rdata_o[7:4] == 4'h0; endproperty
    a_idh: assert property (p_idh) else $error("id high upper nibble");
    property p_lock; spi_pin_select_o |=> $stable(spi_pin_select_o); endproperty
    a_lock: assert property (p_lock) else $error("locked select changed");
    property p_ill; stop_exec_i && !stop_allow_o |=> illegal_stop_reset_o; endproperty
    a_ill: assert property (p_ill) else $error("illegal stop missed");
    property p_stp; stop_exec_i && stop_allow_o |=> stop_enter_o && !illegal_stop_reset_o;
    endproperty
    a_stp: assert property (p_stp) else $error("allowed stop wrong");
endmodule : scor_regs_monitor
bind scor_regs scor_regs_monitor scor_regs_monitor_i (.*);

// ===== test/scor_dbg_host.sv
// Purpose: Debug host model. Assumes: one clock. Notes: released lines show inverted values.
module scor_dbg_host (
    input  wire logic clk_i,
    output logic dbg_wr_o = 1'b0,
    output logic [15:0] dbg_addr_o = 16'h0000,
    output logic [7:0] dbg_wdata_o = 8'h00);
    timeunit 1ns;
    timeprecision 1ns;
    // A reset request goes only through this byte write, never the CPU bus.
    task write_byte(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i) #10 {dbg_wr_o, dbg_addr_o, dbg_wdata_o} = {1'b1, a, d};
        @(posedge clk_i) #10 {dbg_wr_o, dbg_addr_o, dbg_wdata_o} = {1'b0, ~a, ~d};
    endtask : write_byte
endmodule : scor_dbg_host

// ===== test/testbench.sv
// Purpose: Self-checking bench for scor_regs. Assumes: 100 ns clock. Notes: seed 81.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] PID = 12'h5a3; // Arbitrary value.
    logic clk_i = 0, rst_i = 1, cpu_wr_i = 0, cpu_rd_i = 0, stop_exec_i = 0, dbg_wr_i;
    logic [15:0] cpu_addr_i = 0, dbg_addr_i;
    logic [7:0] cpu_wdata_i = 0, dbg_wdata_i, cpu_rdata_o, v;
    logic serial_iface_pin_select_o, spi_pin_select_o, two_wire_pin_select_o, stop_allow_o;
    logic timer2_pin_select_o, fast_wakeup_enable_o, stop_enter_o, force_reset_o;
    logic illegal_stop_reset_o;
    int mismatches = 0, checks_done = 0, cyc = 0, seed = 81;
    scor_regs #(.PART_ID(PID)) scor_regs_i (.*);
    scor_dbg_host scor_dbg_host_i (.clk_i(clk_i), .dbg_wr_o(dbg_wr_i), .dbg_addr_o(dbg_addr_i),
        .dbg_wdata_o(dbg_wdata_i));
    always #50 clk_i = ~clk_i;
    function automatic logic [7:0] exp_sel(input logic [7:0] o);
        return {o[7:4], 2'b00, o[1:0]};
    endfunction : exp_sel
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, s);
            mismatches++;
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i) #10 {cpu_wr_i, cpu_addr_i, cpu_wdata_i} = {1'b1, a, d};
        @(posedge clk_i) #10 cpu_wr_i = 0;
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] e, input string n);
        @(posedge clk_i) #10 {cpu_rd_i, cpu_addr_i} = {1'b1, a};
        @(posedge clk_i) #10 cpu_rd_i = 0;
        chk(n, e, cpu_rdata_o);
    endtask : rd
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    always @(posedge clk_i) if (++cyc > 3000) begin
        mismatches++;
        conclude;
    end
    initial begin
        repeat (6) begin
            rst_i = 1;
            repeat (2) @(posedge clk_i);
            #10 rst_i = 0;
            rd(16'h3004, 8'h0c, "opt_reset");
            rd(16'h3001, 8'h00, "frc_read");
            wr(16'h3003, 8'hff);
            rd(16'h3002, {4'h0, PID[11:8]}, "id_high");
            rd(16'h3003, PID[7:0], "id_low");
            wr(16'h3001, 8'hff);
            chk("cpu_frc", 8'h00, {7'h0, force_reset_o});
            v = 8'($random(seed)) | 8'h0c;
            wr(16'h3004, v);
            wr(16'h3004, ~v | 8'h0c);
            rd(16'h3004, v, "opt_once");
            chk("selects", exp_sel(v), {serial_iface_pin_select_o, spi_pin_select_o,
                two_wire_pin_select_o, timer2_pin_select_o, 2'b00, fast_wakeup_enable_o,
                stop_allow_o});
            scor_dbg_host_i.write_byte(16'h3001, 8'h01);
            chk("dbg_frc", 8'h01, {7'h0, force_reset_o});
            @(posedge clk_i) #10 stop_exec_i = 1;
            @(posedge clk_i) #10 stop_exec_i = 0;
            chk("stop", {6'h0, v[0], ~v[0]},
                {6'h0, stop_enter_o, illegal_stop_reset_o});
            $display("round done options %h", v);
        end
        conclude;
    end
endmodule : testbench
